/* rtl/mcg_defines.vh */
// constants for the machine-check global register block
`ifndef MCG_DEFINES_VH
`define MCG_DEFINES_VH
`define MCG_ADDR_W        12
`define MCG_ADDR_CAP      12'h179
`define MCG_ADDR_STATUS   12'h17A
`define MCG_ADDR_CTL      12'h17B
`define MCG_CAP_COUNT_HI  7
`define MCG_CAP_COUNT_LO  0
`define MCG_CAP_CTLP_BIT  8
`define MCG_ST_RESTART    0
`define MCG_ST_ERRIP      1
`define MCG_ST_INPROG     2
`define MCG_ST_W          3
`define MCG_ST_RESET      3'h0
`define MCG_DATA_W        64
`define MCG_ZERO64        64'h0000000000000000
`endif

/* rtl/mcg_status_reg.v */
// status flags: restart, error-ip and in-progress
`timescale 1ns/1ns
`include "mcg_defines.vh"
module mcg_status_reg (
    input  wire                 mclk,
    input  wire                 rstn,
    input  wire                 raise,
    input  wire                 restartIpValid,
    input  wire                 errorIpAssoc,
    input  wire                 writeEn,
    input  wire [`MCG_ST_W-1:0] writeData,
    output reg  [`MCG_ST_W-1:0] status
);
    reg [`MCG_ST_W-1:0] next_status;

    // raise overrides a same-cycle write so no event is lost
    always @* begin
        next_status = status;
        if (writeEn) begin
            next_status = writeData;
        end
        if (raise) begin
            next_status[`MCG_ST_RESTART] = restartIpValid;
            next_status[`MCG_ST_ERRIP]   = errorIpAssoc;
            next_status[`MCG_ST_INPROG]  = 1'b1;
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status <= `MCG_ST_RESET;
        end else begin
            status <= next_status;
        end
    end
endmodule // mcg_status_reg

/* rtl/mcg_global_regs.v */
// machine-check global capability and status registers
// register map, as seen on the msr port
//   179h  capability, read only
//         7:0   number of error-reporting banks
//         8     global control register present
//         63:9  read as zero
//   17Ah  status, read and write
//         0     saved ip can restart the program
//         1     saved ip is tied to the error
//         2     check in progress
//         63:3  read as zero, writes dropped
//   17Bh  control register; not held here, so reads give no hit
//
// timing on the msr port
//   a read is taken on the edge where msrRead is high;
//   msrRdata and msrHit show the answer for one cycle after it
//   a write is taken on the edge where msrWrite is high;
//   the register holds the new value from that edge on
//
// timing of a check
//   checkDetect is taken on the edge where it is high;
//   with no check in progress the status flags are set at that
//   edge and checkException pulses for the following cycle
//   with a check in progress no exception is given; shutdown
//   rises instead and stays up until reset
//
// limitations
//   only bits 2:0 of the status word are stored
//   a handler write and a check in the same cycle: the check wins, unless a check is already in progress, then the write wins
//   shutdown has no software exit; only rstn clears it
//
`timescale 1ns/1ns
`include "mcg_defines.vh"
module mcg_global_regs #(
    parameter [7:0] BANK_COUNT  = 8'h05,
    parameter       CTL_PRESENT = 1
) (
    input  wire                    mclk,
    input  wire                    rstn,
    input  wire                    msrRead,
    input  wire                    msrWrite,
    input  wire [`MCG_ADDR_W-1:0]  msrAddr,
    input  wire [`MCG_DATA_W-1:0]  msrWdata,
    output reg  [`MCG_DATA_W-1:0]  msrRdata,
    output reg                     msrHit,
    input  wire                    checkDetect,
    input  wire                    restartIpValid,
    input  wire                    errorIpAssoc,
    output reg                     checkException,
    output reg                     shutdown,
    output reg                     checkInProgress
);
    // current status flags, owned by the status register below
    wire [`MCG_ST_W-1:0]   status;
    // decoded address strobes
    wire                   capSel;
    wire                   statusSel;
    wire                   capRead;
    wire                   statusRead;
    wire                   capWrite;
    wire                   statusWrite;
    // check qualification
    wire                   raise;
    wire                   nested;
    wire                   next_inProgress;
    // read words and next values of the registered outputs
    reg  [`MCG_DATA_W-1:0] capWord;
    reg  [`MCG_DATA_W-1:0] statusWord;
    reg  [`MCG_DATA_W-1:0] next_msrRdata;
    reg                    next_msrHit;
    reg                    next_shutdown;

    // address decode, shared by read and write paths
    assign capSel     = (msrAddr == `MCG_ADDR_CAP);
    assign statusSel  = (msrAddr == `MCG_ADDR_STATUS);
    assign capRead    = msrRead && capSel;
    assign statusRead = msrRead && statusSel;

    // capability writes dropped
    // decoded only to show that nothing consumes it
    assign capWrite = msrWrite && capSel;

    assign statusWrite = msrWrite && statusSel;

    // no second exception
    // a check while busy is never raised, so the flags keep the
    // first check's story for the handler
    assign raise  = checkDetect && !status[`MCG_ST_INPROG];
    assign nested = checkDetect && status[`MCG_ST_INPROG];

    // in-progress as the status register will hold it after the edge;
    // mirroring the next value keeps the port equal to bit 2
    assign next_inProgress = raise |
                             (statusWrite ? msrWdata[`MCG_ST_INPROG]
                                          : status[`MCG_ST_INPROG]);

    // capability constants
    // built from parameters only, so no write can reach it
    always @* begin
        capWord = `MCG_ZERO64;
        capWord[`MCG_CAP_COUNT_HI:`MCG_CAP_COUNT_LO] = BANK_COUNT;
        capWord[`MCG_CAP_CTLP_BIT] = (CTL_PRESENT != 0);
    end

    // status word, upper bits read as zero
    always @* begin
        statusWord = `MCG_ZERO64;
        statusWord[`MCG_ST_W-1:0] = status;
    end

    mcg_status_reg uStatus (
        .mclk           (mclk),
        .rstn           (rstn),
        .raise          (raise),
        .restartIpValid (restartIpValid),
        .errorIpAssoc   (errorIpAssoc),
        .writeEn        (statusWrite),
        .writeData      (msrWdata[`MCG_ST_W-1:0]),
        .status         (status)
    );

    // read mux; unmapped reads give zero and no hit
    always @* begin
        next_msrRdata = `MCG_ZERO64;
        next_msrHit   = 1'b0;
        if (capRead) begin
            next_msrRdata = capWord;
            next_msrHit   = 1'b1;
        end else if (statusRead) begin
            next_msrRdata = statusWord;
            next_msrHit   = 1'b1;
        end
    end

    // read path registered, answer stands one cycle
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            msrRdata <= `MCG_ZERO64;
            msrHit   <= 1'b0;
        end else begin
            msrRdata <= next_msrRdata;
            msrHit   <= next_msrHit;
        end
    end

    // nested check shuts down
    // sticky: a core in shutdown has no handler left to clear it
    always @* begin
        next_shutdown = shutdown;
        if (nested) begin
            next_shutdown = 1'b1;
        end
    end

    // exception pulse, in-progress mirror and shutdown
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            checkException  <= 1'b0;
            shutdown        <= 1'b0;
            checkInProgress <= 1'b0;
        end else begin
            checkException  <= raise;
            checkInProgress <= next_inProgress;
            shutdown        <= next_shutdown;
        end
    end
endmodule // mcg_global_regs

/* testbench/mcg_checker.sv */
// checker for the machine-check global registers
`timescale 1ns/1ns
module mcg_checker (input wire mclk, rstn, msrRead, checkDetect,
    restartIpValid, errorIpAssoc, checkException, shutdown,
    checkInProgress, input wire [11:0] msrAddr, input wire [63:0] msrRdata);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire capRd = msrRead && msrAddr == 12'h179;
    // status read in the cycle the exception shows
    wire stRd = checkException && msrRead && msrAddr == 12'h17A;
    property p_cnt; capRd |=> msrRdata[7:0] == 8'h05; endproperty
    a_cnt: assert property (p_cnt) else $error("bank count");
    property p_ctl; capRd |=> msrRdata[8]; endproperty
    a_ctl: assert property (p_ctl) else $error("control flag");
    property p_fix; capRd |=> msrRdata[63:9] == 55'h0; endproperty
    a_fix: assert property (p_fix) else $error("cap upper");
    property p_rip; stRd |=> msrRdata[0] == $past(restartIpValid, 2);
    endproperty
    a_rip: assert property (p_rip) else $error("restart bit");
    property p_eip; stRd |=> msrRdata[1] == $past(errorIpAssoc, 2);
    endproperty
    a_eip: assert property (p_eip) else $error("error ip bit");
    property p_gen; checkDetect && !checkInProgress
        |=> checkException && checkInProgress; endproperty
    a_gen: assert property (p_gen) else $error("no exception");
    property p_nest; checkDetect && checkInProgress
        |=> shutdown && !checkException; endproperty
    a_nest: assert property (p_nest) else $error("no shutdown");
    c_gen: cover property (checkException);
    c_shut: cover property ($rose(shutdown));
    c_cap: cover property (capRd);
endmodule // mcg_checker

/* testbench/testbench.sv */
// self-checking bench for the machine-check global registers
`timescale 1ns/1ns
module testbench;
    reg mclk = 0, rstn = 0, msrRead = 0, msrWrite = 0, checkDetect = 0;
    reg restartIpValid = 0, errorIpAssoc = 0;
    reg [11:0] msrAddr = 12'h0;
    reg [63:0] msrWdata = 64'h0;
    wire [63:0] msrRdata;
    wire msrHit, checkException, shutdown, checkInProgress;
    integer fail_count = 0, total_checks = 0, cyc = 0, i;
    reg [76:0] rows [0:2]; // address, hit, data
    mcg_global_regs DUT (.*);
    always #25 mclk = ~mclk;
    // hang guard, far above the few dozen cycles needed
    always @(posedge mclk) if (++cyc == 500) begin fail_count++; stop_test; end
    task chk(input [64:0] s, e); begin
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: %h vs %h", $time, s, e);
        end
    end endtask
    task rd(input [11:0] a, input [64:0] e); begin
        msrRead = 1; msrAddr = a;
        @(posedge mclk) #1;
        chk({msrHit, msrRdata}, e);
        msrRead = 0; // idle edge so back-to-back reads never retoggle
        @(posedge mclk) #1;
    end endtask
    task wr(input [11:0] a, input [63:0] d); begin
        msrWrite = 1; msrAddr = a; msrWdata = d;
        @(posedge mclk) #1 msrWrite = 0;
    end endtask
    task raise(input r, e); begin
        restartIpValid = r; errorIpAssoc = e; checkDetect = 1;
        @(posedge mclk) #1 checkDetect = 0;
    end endtask
    task stop_test; begin
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    end endtask
    initial begin
        rows[0] = {12'h179, 1'h1, 64'h105};
        rows[1] = {12'h17A, 1'h1, 64'h0};
        rows[2] = {12'h17B, 1'h0, 64'h0}; // unmapped
        repeat (10) @(posedge mclk);
        #1 rstn = 1;
        for (i = 0; i < 3; i++) rd(rows[i][76:65], rows[i][64:0]);
        wr(12'h179, 64'hFFFFFFFFFFFFFFFF);
        rd(12'h179, {1'h1, 64'h105});
        $display("register tests done");
        raise(1'h0, 1'h1);
        chk({checkException, checkInProgress}, 65'h3);
        rd(12'h17A, {1'h1, 64'h6});
        wr(12'h17A, 64'h0); // handler clears in-progress
        chk(checkInProgress, 65'h0);
        raise(1'h1, 1'h0);
        rd(12'h17A, {1'h1, 64'h5});
        raise(1'h1, 1'h1); // second check while in progress
        chk({checkException, shutdown}, 65'h1);
        $display("check tests done");
        rstn = 0; // mid-run reset must clear shutdown and flags
        @(posedge mclk) #1 rstn = 1;
        chk({shutdown, checkInProgress}, 65'h0);
        rd(12'h17A, {1'h1, 64'h0});
        $display("reset test done");
        stop_test;
    end
endmodule // testbench
bind mcg_global_regs mcg_checker chk_i (.*);
